// [bench/ras_core_model.sv]
// Core side model: live key registers
`default_nettype none
module ras_core_model
  import ras_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire ras_key_t restoreKeys,
  input wire logic restoreValid,
  output ras_key_t liveKeys
);
  timeunit 1ns;
  timeprecision 1ps;
  // Keys drift every cycle; a restore pulse loads restoreKeys instead
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      liveKeys <= 24'h123456;
    end else if (restoreValid) begin
      liveKeys <= restoreKeys;
    end else begin
      liveKeys <= liveKeys + 24'h010307;
    end
  end
endmodule // ras_core_model
`default_nettype wire

// [bench/ras_sva.sv]
// Port checker for the return address stack
`default_nettype none
module ras_sva
  import ras_pkg::*;
#(
  parameter int PC_WIDTH = 21
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire ras_op_t coreOp,
  input wire logic [PC_WIDTH-1:0] programCounter,
  input wire ras_key_t liveKeys,
  input wire logic [PC_WIDTH-1:0] topOfStack,
  input wire ras_key_t restoreKeys,
  input wire logic restoreValid,
  input wire logic stackErrorReset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // Stack top after push
  AST_PUSH_TOS: assert property (coreOp.push |=>
    topOfStack == $past(programCounter) || $stable(topOfStack)) else $error("push top wrong");
  // Shadow save and restore paths, and error reset cause
  AST_INT_SHADOW: assert property (coreOp.vectorInt ##1 coreOp.fastReturn |=>
    restoreValid && restoreKeys == $past(liveKeys, 2)) else $error("interrupt shadow wrong");
  AST_CALL_SHADOW: assert property (coreOp.fastCall ##1 coreOp.fastReturn |=>
    restoreValid && restoreKeys == $past(liveKeys, 2)) else $error("call shadow wrong");
  AST_NEST_SHADOW: assert property (coreOp.vectorInt ##1 coreOp.vectorInt ##1 coreOp.fastReturn
    |=> restoreKeys == $past(liveKeys, 2)) else $error("nested shadow wrong");
  AST_RV_CAUSE: assert property (restoreValid |-> $past(coreOp.fastReturn))
    else $error("restore without return");
  AST_SHADOW_HOLD: assert property (!coreOp.fastReturn |=> $stable(restoreKeys))
    else $error("shadow output moved");
  AST_ERR_CAUSE: assert property (stackErrorReset |-> $past(coreOp.push || coreOp.pop))
    else $error("reset request without stack op");
  // Register access handshake
  AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  AST_APB_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_APB_ERR: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule // ras_sva
bind return_address_stack ras_sva #(.PC_WIDTH(PC_WIDTH)) u_sva (.sys_clk(sys_clk), .resetn(resetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .coreOp(coreOp),
  .programCounter(programCounter), .liveKeys(liveKeys), .topOfStack(topOfStack),
  .restoreKeys(restoreKeys), .restoreValid(restoreValid), .stackErrorReset(stackErrorReset));
`default_nettype wire

// [bench/return_address_stack_tb_top.sv]
// Testbench for the return address stack
`default_nettype none
module return_address_stack_tb_top import ras_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam ras_op_t IDLE = 5'h00, PUSH = 5'h10, POP = 5'h08, VEC = 5'h04, CALL = 5'h02, RET = 5'h01;
  logic sys_clk = 1'h0, resetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, restoreValid, stackErrorReset, irq;
  ras_op_t coreOp = IDLE;
  logic [20:0] programCounter = 21'h0, topOfStack, pcNow, pc[3];
  ras_key_t liveKeys, restoreKeys, keyNow, k;
  logic [32:0] expq[$];
  int errCount = 0, nTests = 0;
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  return_address_stack #(.DEPTH(31), .PC_WIDTH(21)) DUT (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .coreOp(coreOp), .programCounter(programCounter), .liveKeys(liveKeys),
    .topOfStack(topOfStack), .restoreKeys(restoreKeys), .restoreValid(restoreValid),
    .stackErrorReset(stackErrorReset), .irq(irq));
  ras_core_model core (.sys_clk(sys_clk), .resetn(resetn), .restoreKeys(restoreKeys),
    .restoreValid(restoreValid), .liveKeys(liveKeys));
  // Compare and count
  task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic finalReport;
    if (errCount == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expq.push_back(e);
    apb(1'h0, a, 32'h0);
  endtask
  // One core operation per cycle
  task automatic op(input ras_op_t o);
    pcNow = 21'($urandom);
    coreOp <= o;
    programCounter <= pcNow;
    @(posedge sys_clk);
    keyNow = liveKeys;
  endtask
  // Read answers against the oldest note
  always @(posedge sys_clk) begin
    if (pready === 1'h1 && pwrite === 1'h0) begin
      chk("apb read", expq.pop_front(), {pslverr, prdata});
    end
  end
  initial begin
    #200000;
    errCount++;
    finalReport;
  end
  initial begin
    void'($urandom(87403));
    repeat (2) @(posedge sys_clk);
    resetn <= 1'h1;
    @(posedge sys_clk);
    rd(OFF_STKSTAT, 33'h0);
    rd(OFF_CONFIG, 33'h0);
    apb(1'h1, OFF_IRQ_MASK, 32'h2);
    for (int i = 0; i < 3; i++) begin
      op(PUSH);
      pc[i] = pcNow;
      op(IDLE);
      chk("top push", 33'(pc[i]), 33'(topOfStack));
    end
    rd(OFF_STKSTAT, 33'h3);
    rd(OFF_TOP_LOW, 33'(pc[2][7:0]));
    rd(OFF_TOP_HIGH, 33'(pc[2][15:8]));
    rd(OFF_TOP_UPPER, 33'(pc[2][20:16]));
    apb(1'h1, OFF_TOP_LOW, 32'hA5);
    rd(OFF_TOP_LOW, 33'hA5);
    op(POP);
    op(IDLE);
    chk("top pop", 33'(pc[1]), 33'(topOfStack));
    repeat (3) op(POP);
    op(IDLE);
    chk("no reset", 33'h0, 33'(stackErrorReset));
    op(IDLE);
    chk("irq", 33'h1, 33'(irq));
    rd(OFF_STKSTAT, 33'h40);
    apb(1'h1, OFF_STKSTAT, 32'hC0);
    rd(OFF_STKSTAT, 33'h40);
    apb(1'h1, OFF_STKSTAT, 32'h0);
    rd(OFF_STKSTAT, 33'h0);
    apb(1'h1, OFF_IRQ_STATUS, 32'h3);
    rd(OFF_IRQ_STATUS, 33'h0);
    chk("irq clear", 33'h0, 33'(irq));
    apb(1'h1, OFF_STKSTAT, 32'h1E);
    op(PUSH);
    pc[0] = pcNow;
    op(PUSH);
    op(IDLE);
    chk("top full", 33'(pc[0]), 33'(topOfStack));
    rd(OFF_STKSTAT, 33'h9F);
    rd(OFF_IRQ_STATUS, 33'h1);
    chk("irq masked", 33'h0, 33'(irq));
    apb(1'h1, OFF_CONFIG, 32'h1);
    op(PUSH);
    op(IDLE);
    chk("err reset", 33'h1, 33'(stackErrorReset));
    rd(8'h1C, 33'h100000000);
    for (int j = 0; j < 3; j++) begin
      op(j == 2 ? CALL : VEC);
      if (j == 1) op(VEC);
      k = keyNow;
      op(RET);
      op(IDLE);
      chk("shadow", 33'({1'h1, k}), 33'({restoreValid, restoreKeys}));
    end
    repeat (2) op(IDLE);
    finalReport;
  end
endmodule // return_address_stack_tb_top
`default_nettype wire

// [design/ras_pkg.sv]
// Package for the return address stack: register map, field layout, carriers
`default_nettype none
package ras_pkg;
  // Register byte offsets on APB
  localparam logic [7:0] OFF_STKSTAT = 8'h00;
  localparam logic [7:0] OFF_TOP_LOW = 8'h04;
  localparam logic [7:0] OFF_TOP_HIGH = 8'h08;
  localparam logic [7:0] OFF_TOP_UPPER = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_CONFIG = 8'h18;
  // Stack status register fields
  localparam int FULL_BIT = 7;
  localparam int UNF_BIT = 6;
  localparam int PTR_MSB = 4;
  localparam logic [7:0] STKSTAT_RESET = 8'h00;
  // Interrupt status bits
  localparam int IRQ_FULL_BIT = 0;
  localparam int IRQ_UNF_BIT = 1;
  // Config bit
  localparam int CFG_ERR_RESET_BIT = 0;
  localparam logic CFG_RESET = 1'b0;
  // Stack depth default
  localparam int STACK_DEPTH = 31;

  // Core operation request
  typedef struct packed {
    logic push;
    logic pop;
    logic vectorInt;
    logic fastCall;
    logic fastReturn;
  } ras_op_t;

  // Key registers saved by the shadow stack
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] work;
    logic [7:0] bank;
  } ras_key_t;
endpackage
`default_nettype wire

// [design/return_address_stack.sv]
// Return address stack with shadow register stack and APB register access
//
// Local design decisions: the register addresses and register access over APB.
`default_nettype none
// Contract
// [RULE_01] A push increments the pointer and writes the program counter into the new top entry.
// [RULE_02] A pop decrements the pointer so the previous entry becomes the top.
// [RULE_03] The top entry is readable and writable as three byte registers upper, high and low.
// [RULE_04] The pointer sits in bits 4 to 0 as read/write; bit 5 reads zero.
// [RULE_05] Bit 7 is set when the stack becomes full or overflows and stays set until cleared.
// [RULE_06] Bit 6 is set on underflow and stays set until cleared.
// [RULE_07] Both flags reset to zero and software may only clear them, never set them.
// [RULE_08] With error reset enabled a full or underflow sets the flag and then requests a device reset.
// [RULE_09] With error reset disabled a full or underflow sets the flag without a device reset.
// [RULE_10] One shadow each for status, working and bank select registers, invisible to software.
// [RULE_11] Vectoring to any interrupt loads every shadow with its live register.
// [RULE_12] A fast return from interrupt copies the shadows back into the live registers.
// [RULE_13] A high priority entry during low priority service overwrites the saved shadows.
// [RULE_14] A fast call saves the key registers and a fast subroutine return restores them.
// [RULE_15] Software should save key registers itself in low priority service when both priorities are used.
// [RULE_16] A push at maximum depth neither advances the pointer nor writes beyond the last level.
// [RULE_17] A pop at pointer zero leaves the pointer at zero and sets the underflow flag.
module return_address_stack
  import ras_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int PC_WIDTH = 21
) (
  input wire logic sys_clk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core side
  input wire ras_op_t coreOp,
  input wire logic [PC_WIDTH-1:0] programCounter,
  input wire ras_key_t liveKeys,
  output logic [PC_WIDTH-1:0] topOfStack,
  output ras_key_t restoreKeys,
  output logic restoreValid,
  output logic stackErrorReset,
  output logic irq
);

  // Refuse depths the five-bit pointer cannot reach
  if (DEPTH < 2 || DEPTH > 31 || PC_WIDTH < 17 || PC_WIDTH > 24) begin : g_bad_params
    $error("return_address_stack: unsupported DEPTH or PC_WIDTH");
  end

  // Entry 0 is unused; pointer 0 means empty
  logic [PC_WIDTH-1:0] stackMem [1:DEPTH];
  logic [4:0] stackPtr_reg, stackPtr_next;
  logic fullFlag_reg, fullFlag_next;
  logic unfFlag_reg, unfFlag_next;
  logic [1:0] irqStatus_reg, irqStatus_next;
  logic [1:0] irqMask_reg, irqMask_next;
  logic errResetEn_reg, errResetEn_next;
  ras_key_t shadow_reg, shadow_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [PC_WIDTH-1:0] topOut_reg, topOut_next;
  ras_key_t restore_reg, restore_next;
  logic restoreValid_reg, restoreValid_next;
  logic errReset_reg, errReset_next;
  logic irq_reg, irq_next;

  logic memWrite;
  logic [4:0] memAddr;
  logic [PC_WIDTH-1:0] memData;
  logic fullEvent, unfEvent;
  logic apbTake, apbWrite, apbRead;
  logic [PC_WIDTH-1:0] curTop;
  logic [23:0] topWide;

  localparam logic [4:0] DEPTH_PTR = 5'(DEPTH);

  // Access taken in its first cycle; a write lands at the edge that sees pready
  assign apbTake = psel && penable && !pready_reg;
  assign apbRead = apbTake && !pwrite;
  assign apbWrite = psel && penable && pwrite && pready_reg;
  assign curTop = (stackPtr_reg == 5'h00) ? '0 : stackMem[stackPtr_reg];
  assign topWide = 24'(curTop);

  // Stack pointer, entries and flags
  always_comb begin
    stackPtr_next = stackPtr_reg;
    fullFlag_next = fullFlag_reg;
    unfFlag_next = unfFlag_reg;
    memWrite = 1'b0;
    memAddr = stackPtr_reg;
    memData = programCounter;
    fullEvent = 1'b0;
    unfEvent = 1'b0;
    // Software access to pointer, flags and top entry
    if (apbWrite) begin
      if (paddr == OFF_STKSTAT) begin
        stackPtr_next = pwdata[PTR_MSB:0]; // RULE_04
        if (stackPtr_next > DEPTH_PTR) begin
          stackPtr_next = DEPTH_PTR;
        end
        if (!pwdata[FULL_BIT]) begin
          fullFlag_next = 1'b0; // RULE_07
        end
        if (!pwdata[UNF_BIT]) begin
          unfFlag_next = 1'b0; // RULE_07
        end
      end else if (paddr == OFF_TOP_LOW && stackPtr_reg != 5'h00) begin
        memWrite = 1'b1; // RULE_03
        memData = PC_WIDTH'({topWide[23:8], pwdata[7:0]});
      end else if (paddr == OFF_TOP_HIGH && stackPtr_reg != 5'h00) begin
        memWrite = 1'b1; // RULE_03
        memData = PC_WIDTH'({topWide[23:16], pwdata[7:0], topWide[7:0]});
      end else if (paddr == OFF_TOP_UPPER && stackPtr_reg != 5'h00) begin
        memWrite = 1'b1; // RULE_03
        memData = PC_WIDTH'({pwdata[7:0], topWide[15:0]});
      end
    end
    // Core push and pop win over a software pointer write, except a push at full depth or a pop at pointer zero
    if (coreOp.push) begin
      if (stackPtr_reg >= DEPTH_PTR) begin
        fullEvent = 1'b1; // RULE_16
      end else begin
        stackPtr_next = stackPtr_reg + 5'h01; // RULE_01
        memWrite = 1'b1; // RULE_01
        memAddr = stackPtr_reg + 5'h01;
        memData = programCounter;
        if (stackPtr_reg + 5'h01 == DEPTH_PTR) begin
          fullEvent = 1'b1; // RULE_05
        end
      end
    end else if (coreOp.pop) begin
      if (stackPtr_reg == 5'h00) begin
        unfEvent = 1'b1; // RULE_17
      end else begin
        stackPtr_next = stackPtr_reg - 5'h01; // RULE_02
      end
    end
    // Set wins over a clear in the same cycle
    if (fullEvent) begin
      fullFlag_next = 1'b1; // RULE_05
    end
    if (unfEvent) begin
      unfFlag_next = 1'b1; // RULE_06
    end
  end

  // Interrupt mask and error reset enable, software written
  always_comb begin
    irqMask_next = irqMask_reg;
    errResetEn_next = errResetEn_reg;
    if (apbWrite && paddr == OFF_IRQ_MASK) begin
      irqMask_next = pwdata[1:0];
    end else if (apbWrite && paddr == OFF_CONFIG) begin
      errResetEn_next = pwdata[CFG_ERR_RESET_BIT];
    end
  end

  // Interrupt status: sticky, write one to clear, set wins
  always_comb begin
    irqStatus_next = irqStatus_reg;
    if (apbWrite && paddr == OFF_IRQ_STATUS) begin
      irqStatus_next = irqStatus_reg & ~pwdata[1:0];
    end
    if (fullEvent) begin
      irqStatus_next[IRQ_FULL_BIT] = 1'b1;
    end
    if (unfEvent) begin
      irqStatus_next[IRQ_UNF_BIT] = 1'b1;
    end
    irq_next = |(irqStatus_next & irqMask_next);
  end

  // Error reset request pulse, raised at the edge that sets the flag
  always_comb begin
    errReset_next = 1'b0;
    if (errResetEn_reg && (fullEvent || unfEvent)) begin
      errReset_next = 1'b1; // RULE_08
    end else if (!errResetEn_reg) begin
      errReset_next = 1'b0; // RULE_09
    end
  end

  // Shadow register stack, hidden from software
  always_comb begin
    shadow_next = shadow_reg;
    restore_next = restore_reg;
    restoreValid_next = 1'b0;
    if (coreOp.vectorInt || coreOp.fastCall) begin
      shadow_next = liveKeys; // RULE_11 RULE_13 RULE_14
    end
    if (coreOp.fastReturn) begin
      restore_next = shadow_reg; // RULE_12 RULE_14
      restoreValid_next = 1'b1; // RULE_10
    end
  end

  // APB read data and one-wait-state answer
  always_comb begin
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    pready_next = 1'b0;
    if (apbTake) begin
      pready_next = 1'b1;
      prdata_next = 32'h0000_0000;
      if (paddr == OFF_STKSTAT) begin
        prdata_next[7:0] = {fullFlag_reg, unfFlag_reg, 1'b0, stackPtr_reg}; // RULE_04
      end else if (paddr == OFF_TOP_LOW) begin
        prdata_next[7:0] = topWide[7:0]; // RULE_03
      end else if (paddr == OFF_TOP_HIGH) begin
        prdata_next[7:0] = topWide[15:8];
      end else if (paddr == OFF_TOP_UPPER) begin
        prdata_next[7:0] = topWide[23:16];
      end else if (paddr == OFF_IRQ_STATUS) begin
        prdata_next[1:0] = irqStatus_reg;
      end else if (paddr == OFF_IRQ_MASK) begin
        prdata_next[1:0] = irqMask_reg;
      end else if (paddr == OFF_CONFIG) begin
        prdata_next[0] = errResetEn_reg;
      end else begin
        pslverr_next = 1'b1;
      end
      if (!apbRead) begin
        prdata_next = 32'h0000_0000;
      end
    end
  end

  // Top of stack output follows the next entry value
  always_comb begin
    topOut_next = curTop;
    if (memWrite && memAddr == stackPtr_next) begin
      topOut_next = memData;
    end else if (stackPtr_next == 5'h00) begin
      topOut_next = '0;
    end else if (stackPtr_next != stackPtr_reg) begin
      topOut_next = stackMem[stackPtr_next];
    end
  end

  // Stack entry storage
  always_ff @(posedge sys_clk) begin
    if (memWrite && memAddr != 5'h00) begin
      stackMem[memAddr] <= memData;
    end
  end

  // Stack pointer and sticky flags
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      stackPtr_reg <= STKSTAT_RESET[PTR_MSB:0];
      fullFlag_reg <= STKSTAT_RESET[FULL_BIT]; // RULE_07
      unfFlag_reg <= STKSTAT_RESET[UNF_BIT]; // RULE_07
    end else begin
      stackPtr_reg <= stackPtr_next;
      fullFlag_reg <= fullFlag_next;
      unfFlag_reg <= unfFlag_next;
    end
  end

  // Interrupt mask and error reset enable
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irqMask_reg <= 2'h0;
      errResetEn_reg <= CFG_RESET;
    end else begin
      irqMask_reg <= irqMask_next;
      errResetEn_reg <= errResetEn_next;
    end
  end

  // Interrupt status and line
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irqStatus_reg <= 2'h0;
      irq_reg <= 1'h0;
    end else begin
      irqStatus_reg <= irqStatus_next;
      irq_reg <= irq_next;
    end
  end

  // Error reset request pulse
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      errReset_reg <= 1'h0;
    end else begin
      errReset_reg <= errReset_next;
    end
  end

  // Shadow copy and restore pulse
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      shadow_reg <= '0;
      restore_reg <= '0;
      restoreValid_reg <= 1'h0;
    end else begin
      shadow_reg <= shadow_next;
      restore_reg <= restore_next;
      restoreValid_reg <= restoreValid_next;
    end
  end

  // APB answer registers
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'h0;
      pslverr_reg <= 1'h0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // Top of stack output register
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      topOut_reg <= '0;
    end else begin
      topOut_reg <= topOut_next;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign topOfStack = topOut_reg;
  assign restoreKeys = restore_reg;
  assign restoreValid = restoreValid_reg;
  assign stackErrorReset = errReset_reg;
  assign irq = irq_reg;

endmodule // return_address_stack
`default_nettype wire
